// ===== src/pmx_map.svh
// Constants of the MAC-side data port: register offsets, fields, timings.
// Assumes a 125 MHz system clock; included by the port only.
`ifndef PMX_MAP_SVH
`define PMX_MAP_SVH
// Register offsets (word index on the plain register port)
`define PMX_ADDR_CTRL 4'h0
`define PMX_ADDR_STAT 4'h1
// Control field positions
`define PMX_C_THR_LO 0
`define PMX_C_RMII 2
`define PMX_C_MASTER 3
`define PMX_C_SCTX 4
`define PMX_C_SCRX 5
`define PMX_C_SPD100 6
`define PMX_C_FDX 7
`define PMX_C_HBEAT 8
`define PMX_C_SRST 9
`define PMX_CTRL_RST 16'h0041
// Status field positions
`define PMX_S_UNDER 0
`define PMX_S_OVER 1
`define PMX_S_CRS 2
`define PMX_S_COL 3
`define PMX_S_RXBUSY 4
// Timing, in ns, and derived counts of system clocks
`define PMX_SYS_NS 8
`define PMX_COL_QUAL_NS 700
`define PMX_SQE_DLY_NS 1000
`define PMX_SQE_LEN_NS 1000
`define PMX_COL_QUAL_CYC ((`PMX_COL_QUAL_NS + `PMX_SYS_NS - 1) / `PMX_SYS_NS)
`define PMX_SQE_DLY_CYC (`PMX_SQE_DLY_NS / `PMX_SYS_NS)
`define PMX_SQE_LEN_CYC (`PMX_SQE_LEN_NS / `PMX_SYS_NS)
// Last value of the shared reference edge counter, which wraps every 40 edges
`define PMX_EDGE_WRAP 6'd39
`endif

// ===== src/pmx_pkg.sv
// Types shared by the MAC-side data port.
// Assumes pmx_map.svh is on the include path.
package pmx_pkg;
	typedef enum logic [1:0] {RX_IDLE, RX_FILL, RX_SEND} pmx_rx_e;
	typedef logic [5:0] pmx_cnt_t;
endpackage : pmx_pkg

// ===== src/pmx_port.sv
// MAC-facing data port of a 10/100 transceiver: MII, RMII, single-clock MII.
// Assumes line-side strobes are synchronous to SYS_CLK and OSC_STB marks
// one edge of the oscillator reference (two per reference period).
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "pmx_map.svh"

// How it works
// - Half duplex: receive and transmit active together raises collision.
// - Transmitting at 10 Mb, collision waits seven bit times, then holds.
// - Collision found while receiving is reported at once.
// - Heartbeat at 10 Mb: ten-bit pulse on collision about 1 us after packet.
// - Full duplex never shows collision.
// - 10 Mb carrier sense needs squelch to qualify receive data.
// - 100 Mb carrier sense needs signal detect and two separate zeros.
// - Half duplex carrier sense covers both transmit and receive.
// - Full duplex carrier sense is receive only; drops at packet end.
// - RMII moves two bits per 50 MHz reference cycle each way.
// - RMII also drives a separate receive data valid output.
// - Receive error for symbol errors, false carrier, buffer faults.
// - Any receive error corrupts the data handed to the MAC.
// - RMII at 10 Mb samples and presents data every tenth clock.
// - Buffer fault corrupts the packet and sets a sticky status bit.
// - RMII start threshold: 01 2/8, 10 6/4, 11 10/8, 00 14/12 bits.
// - Single-clock start threshold: 4 or 8 bits at 100, 8 at 10.
// - RMII master drives 50 MHz on all clock pins; receive clock 25 MHz in reset.
// - RMII slave halves the 50 MHz input for the non-RMII clock.
// - Single-clock mode moves nibbles on 25 MHz; every tenth at 10 Mb.
// - Separate transmit and receive single-clock enable bits are stored but steer nothing; buffer always.
// - Normal MII clocks run at 2.5 or 25 MHz with nibble data.
module pmx_port
	import pmx_pkg::*;
#(
	parameter int BUF_BITS = 32
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	// Register port
	input wire logic [3:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [15:0] REG_RDATA,
	// Oscillator reference edge
	input wire logic OSC_STB,
	// Line side receive
	input wire logic LINE_RX_ACTIVE,
	input wire logic LINE_RX_NIB_VLD,
	input wire logic [3:0] LINE_RX_NIB,
	input wire logic LINE_SYM_ERR,
	input wire logic LINE_FALSE_CARRIER,
	input wire logic SQUELCH_OK,
	input wire logic SIGNAL_DETECT_INDICATION,
	input wire logic LINE_ZERO_STB,
	// Line side transmit
	output logic LINE_TX_VLD,
	output logic [3:0] LINE_TX_DAT,
	// MAC transmit
	input wire logic TX_EN,
	input wire logic [3:0] TXD,
	// MAC receive and status
	output logic [3:0] RXD,
	output logic RX_DV,
	output logic RX_ER,
	output logic CRS,
	output logic COL,
	// Clock pins
	output logic RX_CLK_OUT,
	output logic TX_CLK_OUT,
	output logic CLK_OUT
);
	localparam int PW = $clog2(BUF_BITS);

	logic rst_a_ff, rst_b_ff;
	logic [15:0] ctrl_ff;
	logic under_ff, over_ff;
	pmx_cnt_t edge_ff;
	logic xfer_tick;
	logic [5:0] xfer_n, clk_n, rxclk_n;
	logic buf_ff [BUF_BITS];
	logic [PW-1:0] wr_ff, rd_ff;
	logic [PW:0] cnt_ff;
	logic [3:0] thr_ff;
	pmx_rx_e rx_st_ff;
	logic err_ff;
	logic rd_go, wr_go, under_ev, over_ev;
	logic [2:0] rw;
	logic tx_first_ff;
	logic [7:0] col_cnt_ff;
	logic [8:0] sqe_cnt_ff;
	logic tx_d_ff;
	logic [1:0] zero_cnt_ff;
	logic zero_d_ff, crs_rx_ff;
	logic rmii, spd, fdx, col_raw, col_q, sqe_on;

	// Reset release through two flops
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_a_ff <= 1'b0;
			rst_b_ff <= 1'b0;
		end else begin
			rst_a_ff <= 1'b1;
			rst_b_ff <= rst_a_ff;
		end
	end

	assign rmii = ctrl_ff[`PMX_C_RMII];
	assign spd = ctrl_ff[`PMX_C_SPD100];
	assign fdx = ctrl_ff[`PMX_C_FDX];

	// True on the edges that end a period of n reference edges
	function automatic logic hit(input pmx_cnt_t c, input logic [5:0] n);
		logic h;
		h = 1'b0;
		unique case (n)
			6'd1: h = 1'b1;
			6'd2: h = (c[0] == 1'b0);
			6'd4: h = (c[1:0] == 2'b00);
			6'd20: h = (c == 6'd0) || (c == 6'd20);
			default: h = (c == 6'd0);
		endcase
		return h;
	endfunction : hit

	// Start threshold in bits for mode, speed and code
	function automatic logic [3:0] thr_bits(input logic rm,
		input logic s100, input logic [1:0] code);
		logic [3:0] t;
		t = 4'h8;
		if (rm) begin
			unique case (code)
				2'b01: t = s100 ? 4'h2 : 4'h8;
				2'b10: t = s100 ? 4'h6 : 4'h4;
				2'b11: t = s100 ? 4'ha : 4'h8;
				2'b00: t = s100 ? 4'he : 4'hc;
			endcase
		end else if (s100) begin
			t = code[0] ^ code[1] ? 4'h4 : 4'h8;
		end
		return t;
	endfunction : thr_bits

	// Register writes; soft reset and modes steer the port
	// single-clock enables kept apart
	always_ff @(posedge SYS_CLK or negedge rst_b_ff) begin
		if (!rst_b_ff) begin
			ctrl_ff <= `PMX_CTRL_RST;
		end else if (REG_WR && REG_ADDR == `PMX_ADDR_CTRL) begin
			ctrl_ff <= {6'h00, REG_WDATA[9:0]};
		end
	end

	// Read data one cycle after the strobe, zero elsewhere
	always_ff @(posedge SYS_CLK or negedge rst_b_ff) begin
		if (!rst_b_ff) begin
			REG_RDATA <= 16'h0000;
		end else if (REG_RD && REG_ADDR == `PMX_ADDR_CTRL) begin
			REG_RDATA <= ctrl_ff;
		end else if (REG_RD && REG_ADDR == `PMX_ADDR_STAT) begin
			REG_RDATA <= {11'h000, rx_st_ff != RX_IDLE, COL, CRS,
				over_ff, under_ff};
		end else begin
			REG_RDATA <= 16'h0000;
		end
	end

	// Reference edge counter shared by all dividers
	always_ff @(posedge SYS_CLK or negedge rst_b_ff) begin
		if (!rst_b_ff) begin
			edge_ff <= 6'd0;
		end else if (OSC_STB) begin
			edge_ff <= (edge_ff == `PMX_EDGE_WRAP) ? 6'd0 : edge_ff + 6'd1;
		end
	end

	// transfer cadence per mode and speed
	always_comb begin
		if (rmii) begin
			xfer_n = spd ? 6'd2 : 6'd20;
			clk_n = ctrl_ff[`PMX_C_MASTER] ? 6'd1 : 6'd2;
		end else begin
			xfer_n = spd ? 6'd4 : 6'd40;
			clk_n = spd ? 6'd2 : 6'd20;
		end
		// receive clock at 25 MHz while held in reset
		rxclk_n = ctrl_ff[`PMX_C_SRST] ? 6'd2 : clk_n;
	end
	assign xfer_tick = OSC_STB && hit(edge_ff, xfer_n);

	// clock pins toggle at half period boundaries
	always_ff @(posedge SYS_CLK or negedge rst_b_ff) begin
		if (!rst_b_ff) begin
			RX_CLK_OUT <= 1'b0;
			TX_CLK_OUT <= 1'b0;
			CLK_OUT <= 1'b0;
		end else if (OSC_STB) begin
			if (hit(edge_ff, rxclk_n))
				RX_CLK_OUT <= !RX_CLK_OUT;
			if (hit(edge_ff, clk_n)) begin
				TX_CLK_OUT <= !TX_CLK_OUT;
				CLK_OUT <= !CLK_OUT;
			end
		end
	end

	// transmit data taken once per transfer slot
	always_ff @(posedge SYS_CLK or negedge rst_b_ff) begin
		if (!rst_b_ff) begin
			LINE_TX_VLD <= 1'b0;
			LINE_TX_DAT <= 4'h0;
		end else if (xfer_tick && !ctrl_ff[`PMX_C_SRST]) begin
			LINE_TX_VLD <= TX_EN;
			LINE_TX_DAT <= rmii ? {2'b00, TXD[1:0]} : TXD;
		end else begin
			LINE_TX_VLD <= 1'b0;
		end
	end

	// Receive elasticity buffer; used in every mode so latency is uniform
	assign rw = rmii ? 3'd2 : 3'd4;
	assign wr_go = LINE_RX_NIB_VLD && rx_st_ff != RX_IDLE;
	assign rd_go = xfer_tick && rx_st_ff == RX_SEND;
	assign over_ev = wr_go && cnt_ff > (PW+1)'(BUF_BITS - 4);
	assign under_ev = rd_go && LINE_RX_ACTIVE && cnt_ff < (PW+1)'(rw);

	always_ff @(posedge SYS_CLK) begin
		if (wr_go && !over_ev) begin
			for (int i = 0; i < 4; i++)
				buf_ff[wr_ff + PW'(i)] <= LINE_RX_NIB[i];
		end
	end

	// Pointers, fill count and frame state
	always_ff @(posedge SYS_CLK or negedge rst_b_ff) begin
		if (!rst_b_ff) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
			rx_st_ff <= RX_IDLE;
			thr_ff <= 4'h2;
		end else begin
			unique case (rx_st_ff)
				RX_IDLE: begin
					wr_ff <= '0;
					rd_ff <= '0;
					cnt_ff <= '0;
					thr_ff <= thr_bits(rmii, spd, ctrl_ff[1:0]);
					if (LINE_RX_ACTIVE)
						rx_st_ff <= RX_FILL;
				end
				RX_FILL: begin
					if (wr_go) begin
						wr_ff <= wr_ff + PW'(4);
						cnt_ff <= cnt_ff + (PW+1)'(4);
					end
					// start once threshold bits are held
					if (cnt_ff >= (PW+1)'(thr_ff) || !LINE_RX_ACTIVE)
						rx_st_ff <= RX_SEND;
				end
				RX_SEND: begin
					if (wr_go && !over_ev)
						wr_ff <= wr_ff + PW'(4);
					if (rd_go && !under_ev)
						rd_ff <= rd_ff + PW'(rw);
					cnt_ff <= cnt_ff
						+ ((wr_go && !over_ev) ? (PW+1)'(4) : '0)
						- ((rd_go && !under_ev) ? (PW+1)'(rw) : '0);
					if (!LINE_RX_ACTIVE && cnt_ff < (PW+1)'(rw))
						rx_st_ff <= RX_IDLE;
				end
				default: rx_st_ff <= RX_IDLE;
			endcase
		end
	end

	// error held for rest of frame
	always_ff @(posedge SYS_CLK or negedge rst_b_ff) begin
		if (!rst_b_ff) begin
			err_ff <= 1'b0;
		end else if (rx_st_ff == RX_IDLE && !LINE_RX_ACTIVE) begin
			err_ff <= LINE_FALSE_CARRIER;
		end else if (over_ev || under_ev || LINE_FALSE_CARRIER
			|| (LINE_SYM_ERR && LINE_RX_ACTIVE)) begin
			err_ff <= 1'b1;
		end
	end

	// sticky buffer faults; set wins over write-one clear
	always_ff @(posedge SYS_CLK or negedge rst_b_ff) begin
		if (!rst_b_ff) begin
			under_ff <= 1'b0;
			over_ff <= 1'b0;
		end else begin
			if (under_ev)
				under_ff <= 1'b1;
			else if (REG_WR && REG_ADDR == `PMX_ADDR_STAT
				&& REG_WDATA[`PMX_S_UNDER])
				under_ff <= 1'b0;
			if (over_ev)
				over_ff <= 1'b1;
			else if (REG_WR && REG_ADDR == `PMX_ADDR_STAT
				&& REG_WDATA[`PMX_S_OVER])
				over_ff <= 1'b0;
		end
	end

	// receive data out, corrupted while in error
	always_ff @(posedge SYS_CLK or negedge rst_b_ff) begin
		if (!rst_b_ff) begin
			RXD <= 4'h0;
			RX_DV <= 1'b0;
			RX_ER <= 1'b0;
		end else if (xfer_tick) begin
			RX_DV <= rd_go && !under_ev;
			RX_ER <= rd_go && (err_ff || under_ev || over_ev);
			for (int i = 0; i < 4; i++)
				RXD[i] <= (i < int'(rw) && rd_go)
					? buf_ff[rd_ff + PW'(i)] ^ (err_ff || under_ev) : 1'b0;
		end
	end

	// 100 Mb zeros count only when not back to back
	always_ff @(posedge SYS_CLK or negedge rst_b_ff) begin
		if (!rst_b_ff) begin
			zero_d_ff <= 1'b0;
			zero_cnt_ff <= 2'd0;
		end else begin
			zero_d_ff <= LINE_ZERO_STB;
			if (!SIGNAL_DETECT_INDICATION || !LINE_RX_ACTIVE)
				zero_cnt_ff <= 2'd0;
			else if (LINE_ZERO_STB && !zero_d_ff && zero_cnt_ff != 2'd2)
				zero_cnt_ff <= zero_cnt_ff + 2'd1;
		end
	end

	// receive carrier, dropped at end of packet
	always_ff @(posedge SYS_CLK or negedge rst_b_ff) begin
		if (!rst_b_ff) begin
			crs_rx_ff <= 1'b0;
		end else if (!LINE_RX_ACTIVE) begin
			crs_rx_ff <= 1'b0;
		end else if (spd) begin
			crs_rx_ff <= SIGNAL_DETECT_INDICATION && zero_cnt_ff == 2'd2;
		end else if (SQUELCH_OK) begin
			crs_rx_ff <= 1'b1;
		end
	end

	// carrier pin; half duplex adds own transmission
	always_ff @(posedge SYS_CLK or negedge rst_b_ff) begin
		if (!rst_b_ff)
			CRS <= 1'b0;
		else
			CRS <= crs_rx_ff || (!fdx && TX_EN);
	end

	// collision is both channels active; order decides qualify
	assign col_raw = !fdx && TX_EN && LINE_RX_ACTIVE;
	always_ff @(posedge SYS_CLK or negedge rst_b_ff) begin
		if (!rst_b_ff) begin
			tx_first_ff <= 1'b0;
			col_cnt_ff <= 8'd0;
		end else begin
			if (!TX_EN)
				tx_first_ff <= 1'b0;
			else if (!tx_d_ff)
				tx_first_ff <= !LINE_RX_ACTIVE;
			if (!col_raw)
				col_cnt_ff <= 8'd0;
			else if (col_cnt_ff != 8'hff)
				col_cnt_ff <= col_cnt_ff + 8'd1;
		end
	end
	// seven bit times at 10 Mb before reporting
	assign col_q = col_raw && (spd || !tx_first_ff
		|| col_cnt_ff >= 8'(`PMX_COL_QUAL_CYC));

	// heartbeat delay then pulse after each 10 Mb packet
	always_ff @(posedge SYS_CLK or negedge rst_b_ff) begin
		if (!rst_b_ff) begin
			tx_d_ff <= 1'b0;
			sqe_cnt_ff <= 9'd0;
		end else begin
			tx_d_ff <= TX_EN;
			if (tx_d_ff && !TX_EN && !spd && ctrl_ff[`PMX_C_HBEAT])
				sqe_cnt_ff <= 9'd1;
			else if (sqe_cnt_ff != 9'd0 && sqe_cnt_ff <
				9'(`PMX_SQE_DLY_CYC + `PMX_SQE_LEN_CYC))
				sqe_cnt_ff <= sqe_cnt_ff + 9'd1;
			else
				sqe_cnt_ff <= 9'd0;
		end
	end
	assign sqe_on = sqe_cnt_ff > 9'(`PMX_SQE_DLY_CYC);

	// collision pin silent in full duplex
	always_ff @(posedge SYS_CLK or negedge rst_b_ff) begin
		if (!rst_b_ff)
			COL <= 1'b0;
		else
			COL <= !fdx && (col_q || sqe_on);
	end

	fdx_no_col_a: assert property (@(posedge SYS_CLK) disable iff (!rst_b_ff)
		$past(fdx) |-> !COL) else $error("collision in full duplex");
	rx_col_now_a: assert property (@(posedge SYS_CLK) disable iff (!rst_b_ff)
		(col_raw && !tx_first_ff) |=> COL) else $error("late collision");
	tx_col_wait_a: assert property (@(posedge SYS_CLK)
		disable iff (!rst_b_ff)
		(col_raw && tx_first_ff && !spd && col_cnt_ff < 8'd80 && !sqe_on)
		|=> !COL) else $error("collision not qualified");
	hdx_tx_crs_a: assert property (@(posedge SYS_CLK) disable iff (!rst_b_ff)
		(!fdx && TX_EN) |=> CRS) else $error("no carrier on transmit");
	fdx_crs_rx_a: assert property (@(posedge SYS_CLK) disable iff (!rst_b_ff)
		(fdx && !LINE_RX_ACTIVE ##1 fdx && !LINE_RX_ACTIVE) |=> !CRS)
		else $error("carrier without receive");
	under_stick_a: assert property (@(posedge SYS_CLK)
		disable iff (!rst_b_ff) under_ev |=> under_ff [*2])
		else $error("underrun not held");
	err_flag_a: assert property (@(posedge SYS_CLK) disable iff (!rst_b_ff)
		(xfer_tick && rd_go && err_ff) |=> RX_ER)
		else $error("error not flagged");
	thr_hold_a: assert property (@(posedge SYS_CLK) disable iff (!rst_b_ff)
		(rx_st_ff != RX_IDLE) |=> $stable(thr_ff))
		else $error("threshold moved in frame");
	sqe_pulse_a: assert property (@(posedge SYS_CLK) disable iff (!rst_b_ff)
		(sqe_cnt_ff == 9'd1 && !fdx) |-> ##126 COL)
		else $error("heartbeat missing");
endmodule : pmx_port

// ===== sim/pmx_mac_model.sv
// Transmit side of the attached MAC: sends a counted burst of nibbles.
// Assumes the port answers each taken slot with a one-cycle LINE_TX_VLD.
`timescale 1ns/1ps
module pmx_mac_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Burst request from the bench
	input wire logic go,
	input wire logic [7:0] len,
	// Slot taken by the port
	input wire logic taken,
	// Towards the port
	output logic tx_en,
	output logic [3:0] txd
);
	logic en_ff;
	logic [3:0] dat_ff;
	logic [7:0] cnt_ff;

	assign tx_en = en_ff;
	assign txd = dat_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			en_ff <= 1'b0;
			dat_ff <= 4'h0;
			cnt_ff <= 8'h00;
		end else if (!en_ff) begin
			// Idle data wanders so a stale value is never mistaken for data
			dat_ff <= ~dat_ff;
			if (go) begin
				en_ff <= 1'b1;
				dat_ff <= 4'h1;
				cnt_ff <= len;
			end
		end else if (taken) begin
			dat_ff <= dat_ff + 4'h1;
			cnt_ff <= cnt_ff - 8'h01;
			if (cnt_ff == 8'h01) begin
				en_ff <= 1'b0;
			end
		end
	end
endmodule : pmx_mac_model

// ===== sim/pmx_port_bench.sv
// Self-checking bench of the MAC-side data port.
// Assumes pmx_pkg, pmx_port and pmx_mac_model are compiled before it.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module pmx_port_bench;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0, rd = 1'b0, osc = 1'b0, rx_act = 1'b0, nib_vld = 1'b0;
	logic sym_err = 1'b0, squelch = 1'b0, sdet = 1'b0, zero_stb = 1'b0;
	logic go = 1'b0;
	logic [7:0] len = 8'h04;
	logic [2:0] osc_cnt = 3'd0;
	logic [15:0] rdata;
	logic [3:0] txd, line_tx_dat, rxd;
	logic tx_en, line_tx_vld, rx_dv, rx_er, crs, col;
	logic rx_clk, clk_out, clk_out_d = 1'b0, rx_clk_d = 1'b0;
	logic [3:0] exp_tx = 4'h1;
	int err_total = 0, check_count = 0, cyc = 0;
	int tog = 0, tog_rx = 0;

	pmx_port #(.BUF_BITS(32)) dut_u (.SYS_CLK(sys_clk), .RESET_N(rst_n),
		.REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
		.REG_RDATA(rdata), .OSC_STB(osc), .LINE_RX_ACTIVE(rx_act),
		.LINE_RX_NIB_VLD(nib_vld), .LINE_RX_NIB(4'ha),
		.LINE_SYM_ERR(sym_err), .LINE_FALSE_CARRIER(1'b0),
		.SQUELCH_OK(squelch), .SIGNAL_DETECT_INDICATION(sdet),
		.LINE_ZERO_STB(zero_stb), .LINE_TX_VLD(line_tx_vld),
		.LINE_TX_DAT(line_tx_dat), .TX_EN(tx_en), .TXD(txd), .RXD(rxd),
		.RX_DV(rx_dv), .RX_ER(rx_er), .CRS(crs), .COL(col),
		.RX_CLK_OUT(rx_clk), .TX_CLK_OUT(), .CLK_OUT(clk_out));

	pmx_mac_model mac_u (.clk(sys_clk), .rst_n(rst_n), .go(go), .len(len),
		.taken(line_tx_vld), .tx_en(tx_en), .txd(txd));

	always #4 sys_clk = ~sys_clk;

	// Reference edges in four of five clocks, near the 100 MHz edge rate
	always @(posedge sys_clk) begin
		osc_cnt <= (osc_cnt == 3'd4) ? 3'd0 : osc_cnt + 3'd1;
		osc <= (osc_cnt != 3'd4);
	end

	// Clock pin toggles, and transmit nibbles seen on the line side
	always @(posedge sys_clk) begin
		clk_out_d <= clk_out;
		rx_clk_d <= rx_clk;
		if (clk_out !== clk_out_d) tog++;
		if (rx_clk !== rx_clk_d) tog_rx++;
		if (go) exp_tx <= 4'h1;
		if (line_tx_vld) begin
			`CHK(line_tx_dat, exp_tx)
			exp_tx <= exp_tx + 4'h1;
		end
	end

	// Hang guard: the whole sequence needs well under 8000 cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			close_out();
		end
	end

	function automatic logic pick(input int sel);
		case (sel)
			0: pick = col;
			1: pick = crs;
			2: pick = rx_dv;
			3: pick = rx_er;
			default: pick = tx_en;
		endcase
	endfunction : pick

	task automatic skip(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : skip

	// Bounded wait for a status line, then one comparison
	task automatic wait_for(input int sel, input logic v, input int lim);
		int n;
		n = 0;
		// Look off the edge so launched outputs have settled
		#1;
		while (pick(sel) !== v && n < lim) begin
			skip(1);
			n++;
		end
		`CHK(pick(sel), v)
	endtask : wait_for

	task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1;
		`CHK(rdata, exp)
	endtask : reg_rd

	task automatic send(input logic [7:0] n);
		@(posedge sys_clk);
		len <= n;
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
	endtask : send

	// Nibbles written back to back, n of them
	task automatic push(input int n);
		if (n > 0) begin
			@(posedge sys_clk);
			nib_vld <= 1'b1;
			repeat (n) @(posedge sys_clk);
			nib_vld <= 1'b0;
		end
	endtask : push

	task automatic pulse_zero;
		@(posedge sys_clk);
		zero_stb <= 1'b1;
		@(posedge sys_clk);
		zero_stb <= 1'b0;
	endtask : pulse_zero

	// Toggles of the clock pins over 40 reference edges
	task automatic clk_rate(input logic [15:0] c, input int e_clk,
		input int e_rx);
		reg_wr(4'h0, c);
		skip(4);
		tog = 0;
		tog_rx = 0;
		skip(50);
		`CHK(tog, e_clk)
		`CHK(tog_rx, e_rx)
	endtask : clk_rate

	task automatic close_out;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : close_out

	logic [1:0] codes [4] = '{2'b01, 2'b10, 2'b11, 2'b00};
	int need [4] = '{1, 2, 3, 4};

	initial begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		skip(4);
		// Reset values, unmapped index, unused control bits
		reg_rd(4'h0, 16'h0041);
		reg_rd(4'h1, 16'h0000);
		reg_wr(4'h7, 16'hffff);
		reg_rd(4'h7, 16'h0000);
		reg_wr(4'h0, 16'hfc41);
		reg_rd(4'h0, 16'h0041);
		// Full duplex at 100 Mb
		reg_wr(4'h0, 16'h00c1);
		send(8'd40);
		skip(20);
		`CHK(crs, 1'b0)
		@(posedge sys_clk);
		rx_act <= 1'b1;
		sdet <= 1'b1;
		pulse_zero();
		skip(10);
		`CHK(crs, 1'b0)
		pulse_zero();
		wait_for(1, 1'b1, 4);
		`CHK(col, 1'b0)
		@(posedge sys_clk);
		rx_act <= 1'b0;
		wait_for(1, 1'b0, 4);
		wait_for(4, 1'b0, 400);
		// Half duplex at 100 Mb: overlap gives collision at once
		reg_wr(4'h0, 16'h0041);
		send(8'd40);
		wait_for(1, 1'b1, 20);
		`CHK(col, 1'b0)
		@(posedge sys_clk);
		rx_act <= 1'b1;
		wait_for(0, 1'b1, 2);
		@(posedge sys_clk);
		rx_act <= 1'b0;
		wait_for(0, 1'b0, 3);
		wait_for(4, 1'b0, 400);
		// 10 Mb half duplex with heartbeat
		reg_wr(4'h0, 16'h0101);
		sdet <= 1'b0;
		@(posedge sys_clk);
		rx_act <= 1'b1;
		skip(10);
		`CHK(crs, 1'b0)
		@(posedge sys_clk);
		squelch <= 1'b1;
		wait_for(1, 1'b1, 3);
		@(posedge sys_clk);
		rx_act <= 1'b0;
		squelch <= 1'b0;
		wait_for(1, 1'b0, 3);
		send(8'd2);
		wait_for(4, 1'b1, 5);
		wait_for(4, 1'b0, 300);
		skip(100);
		`CHK(col, 1'b0)
		skip(80);
		`CHK(col, 1'b1)
		skip(100);
		`CHK(col, 1'b0)
		// Transmit first: collision qualified for seven bit times
		send(8'd4);
		skip(10);
		@(posedge sys_clk);
		rx_act <= 1'b1;
		squelch <= 1'b1;
		skip(80);
		`CHK(col, 1'b0)
		wait_for(0, 1'b1, 20);
		@(posedge sys_clk);
		rx_act <= 1'b0;
		wait_for(0, 1'b0, 3);
		wait_for(4, 1'b0, 300);
		skip(300);
		// Receive first: no qualification delay
		@(posedge sys_clk);
		rx_act <= 1'b1;
		skip(5);
		send(8'd2);
		wait_for(0, 1'b1, 10);
		@(posedge sys_clk);
		rx_act <= 1'b0;
		squelch <= 1'b0;
		wait_for(4, 1'b0, 300);
		skip(300);
		// RMII start thresholds, changed only between packets
		for (int i = 0; i < 4; i++) begin
			reg_wr(4'h0, {14'h0011, codes[i]});
			@(posedge sys_clk);
			rx_act <= 1'b1;
			push(need[i] - 1);
			skip(10);
			`CHK(rx_dv, 1'b0)
			push(1);
			wait_for(2, 1'b1, 20);
			@(posedge sys_clk);
			rx_act <= 1'b0;
			skip(100);
		end
		// RMII data pairs, error marking and corruption
		reg_wr(4'h0, 16'h0045);
		@(posedge sys_clk);
		rx_act <= 1'b1;
		push(6);
		wait_for(2, 1'b1, 20);
		`CHK(rxd, 4'h2)
		@(posedge sys_clk);
		sym_err <= 1'b1;
		@(posedge sys_clk);
		sym_err <= 1'b0;
		wait_for(3, 1'b1, 10);
		`CHK(rxd, 4'h1)
		@(posedge sys_clk);
		rx_act <= 1'b0;
		skip(100);
		// Overrun then underrun, sticky with write-one clear
		reg_wr(4'h1, 16'h0003);
		@(posedge sys_clk);
		rx_act <= 1'b1;
		push(16);
		@(posedge sys_clk);
		rx_act <= 1'b0;
		skip(100);
		reg_rd(4'h1, 16'h0002);
		reg_wr(4'h1, 16'h0002);
		reg_rd(4'h1, 16'h0000);
		@(posedge sys_clk);
		rx_act <= 1'b1;
		push(2);
		skip(60);
		@(posedge sys_clk);
		rx_act <= 1'b0;
		skip(20);
		reg_rd(4'h1, 16'h0001);
		reg_wr(4'h0, 16'h0071);
		reg_rd(4'h0, 16'h0071);
		// Clock pin rates per mode
		clk_rate(16'h004d, 40, 40);
		clk_rate(16'h024d, 40, 20);
		clk_rate(16'h0045, 20, 20);
		clk_rate(16'h0041, 20, 20);
		clk_rate(16'h0001, 2, 2);
		close_out();
	end
endmodule : pmx_port_bench
